// ### rtl/csf_cfg.svh
// Reset values and fixed counts of the counter status feedback block
`ifndef CSF_CFG_SVH
`define CSF_CFG_SVH
`define CSF_FLAG_RST      1'b0
`define CSF_SYNC_RST      2'h0
`define CSF_SYNC_STAGES   2
`define CSF_ISO_BUS_STEPS 4
`endif

// ### rtl/csf_pkg.sv
// Types of the counter status feedback block
package csf_pkg;
   typedef enum logic {
      CSF_CLR_IDLE   = 1'b0,
      CSF_CLR_ACTIVE = 1'b1
   } csf_clr_state_t;
   typedef enum logic {
      CSF_LD_IDLE = 1'b0,
      CSF_LD_BUSY = 1'b1
   } csf_ld_state_t;
endpackage : csf_pkg

// ### rtl/csf_sticky.sv
// Sticky flag cell, set wins over clear
`timescale 1ns/10ps
`include "csf_cfg.svh"
module csf_sticky (
   // Clock and reset
   input  wire logic clock_in,
   input  wire logic rst_b_in,
   // Flag control
   input  wire logic set_in,
   input  wire logic clear_in,
   output logic      flag_out
);
   logic flag_reg;
   logic flag_next;

   always_comb begin
      flag_next = set_in | (flag_reg & ~clear_in);
   end

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         flag_reg <= `CSF_FLAG_RST;
      end else begin
         flag_reg <= flag_next;
      end
   end

   assign flag_out = flag_reg;
endmodule : csf_sticky

// ### rtl/csf_status.sv
// Status feedback and acknowledgment logic of the counter channel
`timescale 1ns/10ps
`include "csf_cfg.svh"
// Function
// - Compare-two hit flag set while output two on, held until status clear.
// - Clearing while output two still on sets the flag again at once.
// - Manual output-two level with output two disabled also sets the hit flag.
// - Auxiliary input level is reported in every mode.
// - Output one and virtual output two states are mirrored.
// - Gate open flag follows gate; load busy shows a load being processed.
// - Zero-cross flag set on zero crossing without main direction, held.
// - Upper and lower limit flags set on violation, held until status clear.
// - Sync done flag set after successful synchronization, held until cleared.
// - Load error holds while several commands asserted; cleared by correct load.
// - Isochrone mode: clear and load exchanges advance only on bus cycles.
// - Supply and output-one errors stay latched until the controller acknowledges them.
// - Parameter error cleared only by correct parameter assignment.
// - Diagnostic report only when group diagnostics enabled.
// - Ack held high or master stopped: supply and output-one errors follow their causes.
// - Status flags cleared by request and status-clear-active handshake.
module csf_status
   import csf_pkg::*;
(
   // Clock and reset
   input  wire logic clock_in,
   input  wire logic rst_b_in,
   // Control interface
   input  wire logic status_clear_request_in,
   input  wire logic error_ack_bit_in,
   input  wire logic manual_output_two_level_in,
   input  wire logic output_two_enable_in,
   input  wire logic load_compare_one_in,
   input  wire logic load_compare_two_in,
   input  wire logic load_count_direct_in,
   input  wire logic load_count_staged_in,
   input  wire logic output_param_change_in,
   // Configuration and bus state
   input  wire logic isochrone_mode_in,
   input  wire logic bus_cycle_in,
   input  wire logic master_stop_in,
   input  wire logic group_diag_enable_in,
   // Pin
   input  wire logic auxiliary_input_in,
   // Count engine events
   input  wire logic output_one_in,
   input  wire logic output_two_in,
   input  wire logic gate_open_in,
   input  wire logic no_main_dir_in,
   input  wire logic zero_cross_evt_in,
   input  wire logic upper_limit_evt_in,
   input  wire logic lower_limit_evt_in,
   input  wire logic sync_success_in,
   input  wire logic load_value_bad_in,
   input  wire logic supply_fault_in,
   input  wire logic output_one_fault_in,
   input  wire logic param_error_in,
   input  wire logic param_ok_in,
   // Feedback interface
   output logic      compare_two_hit_flag_out,
   output logic      input_level_flag_out,
   output logic      output_one_state_out,
   output logic      output_two_state_out,
   output logic      gate_open_flag_out,
   output logic      load_busy_flag_out,
   output logic      zero_cross_flag_out,
   output logic      upper_limit_flag_out,
   output logic      lower_limit_flag_out,
   output logic      sync_done_flag_out,
   output logic      status_clear_active_out,
   output logic      load_error_out,
   output logic      supply_error_out,
   output logic      output_one_error_out,
   output logic      param_error_out,
   output logic      diag_report_out,
   // Count engine command
   output logic      load_accept_out
);
   localparam int NUM_LOAD = 5;

   logic [`CSF_SYNC_STAGES-1:0] di_sync_reg;
   logic [`CSF_SYNC_STAGES-1:0] di_sync_next;
   logic [3:0]                  mirror_reg;
   logic [3:0]                  mirror_next;
   logic                        diag_reg;
   logic                        diag_next;
   logic                        accept_reg;
   logic                        accept_next;
   csf_clr_state_t              clr_state_reg;
   csf_clr_state_t              clr_state_next;
   csf_ld_state_t               ld_state_reg;
   csf_ld_state_t               ld_state_next;
   logic                        step;
   logic                        clr_lvl;
   logic                        err_clr;
   logic [NUM_LOAD-1:0]         ld_cmd;
   logic                        ld_any;
   logic                        ld_one;
   logic                        ld_multi;
   logic                        cmp2_set;

   // Isochrone exchanges advance once per bus cycle only
   assign step     = isochrone_mode_in ? bus_cycle_in : 1'b1;
   assign clr_lvl  = (clr_state_reg == CSF_CLR_ACTIVE) & status_clear_request_in;
   assign ld_cmd   = {load_compare_one_in, load_compare_two_in, load_count_direct_in,
                      load_count_staged_in, output_param_change_in};
   assign ld_any   = |ld_cmd;
   assign ld_one   = ld_any & ((ld_cmd & (ld_cmd - 5'h01)) == 5'h00);
   assign ld_multi = ld_any & ~ld_one;
   // Stop or continuous ack turns latching off
   assign err_clr  = error_ack_bit_in | master_stop_in;
   assign cmp2_set = output_two_in | (manual_output_two_level_in & ~output_two_enable_in);

   always_comb begin
      di_sync_next = {di_sync_reg[`CSF_SYNC_STAGES-2:0], auxiliary_input_in};
      mirror_next  = {di_sync_reg[`CSF_SYNC_STAGES-1], output_one_in, output_two_in,
                      gate_open_in};
      diag_next    = group_diag_enable_in &
                     (supply_error_out | output_one_error_out | param_error_out);
   end

   // Status clear handshake
   always_comb begin
      clr_state_next = clr_state_reg;
      case (clr_state_reg)
         CSF_CLR_IDLE: begin
            if (status_clear_request_in && step) begin
               clr_state_next = CSF_CLR_ACTIVE;
            end
         end
         CSF_CLR_ACTIVE: begin
            if (!status_clear_request_in && step) begin
               clr_state_next = CSF_CLR_IDLE;
            end
         end
         default: clr_state_next = CSF_CLR_IDLE;
      endcase
   end

   // Load handshake; a refused mix never reaches the busy state
   always_comb begin
      ld_state_next = ld_state_reg;
      accept_next   = 1'b0;
      case (ld_state_reg)
         CSF_LD_IDLE: begin
            if (ld_one && step && !load_value_bad_in) begin
               ld_state_next = CSF_LD_BUSY;
               accept_next   = 1'b1;
            end
         end
         CSF_LD_BUSY: begin
            if (!ld_any && step) begin
               ld_state_next = CSF_LD_IDLE;
            end
         end
         default: ld_state_next = CSF_LD_IDLE;
      endcase
   end

   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         di_sync_reg   <= `CSF_SYNC_RST;
         mirror_reg    <= 4'h0;
         diag_reg      <= `CSF_FLAG_RST;
         accept_reg    <= `CSF_FLAG_RST;
         clr_state_reg <= CSF_CLR_IDLE;
         ld_state_reg  <= CSF_LD_IDLE;
      end else begin
         di_sync_reg   <= di_sync_next;
         mirror_reg    <= mirror_next;
         diag_reg      <= diag_next;
         accept_reg    <= accept_next;
         clr_state_reg <= clr_state_next;
         ld_state_reg  <= ld_state_next;
      end
   end

   assign input_level_flag_out    = mirror_reg[3];
   assign output_one_state_out    = mirror_reg[2];
   assign output_two_state_out    = mirror_reg[1];
   assign gate_open_flag_out      = mirror_reg[0];
   assign diag_report_out         = diag_reg;
   assign load_accept_out         = accept_reg;
   assign status_clear_active_out = (clr_state_reg == CSF_CLR_ACTIVE);
   assign load_busy_flag_out      = (ld_state_reg == CSF_LD_BUSY);

   csf_sticky u_cmp2 (.clock_in(clock_in), .rst_b_in(rst_b_in), .set_in(cmp2_set),
      .clear_in(clr_lvl), .flag_out(compare_two_hit_flag_out));
   csf_sticky u_zero (.clock_in(clock_in), .rst_b_in(rst_b_in),
      .set_in(zero_cross_evt_in & no_main_dir_in), .clear_in(clr_lvl),
      .flag_out(zero_cross_flag_out));
   csf_sticky u_upper (.clock_in(clock_in), .rst_b_in(rst_b_in), .set_in(upper_limit_evt_in),
      .clear_in(clr_lvl), .flag_out(upper_limit_flag_out));
   csf_sticky u_lower (.clock_in(clock_in), .rst_b_in(rst_b_in), .set_in(lower_limit_evt_in),
      .clear_in(clr_lvl), .flag_out(lower_limit_flag_out));
   csf_sticky u_sync (.clock_in(clock_in), .rst_b_in(rst_b_in), .set_in(sync_success_in),
      .clear_in(clr_lvl), .flag_out(sync_done_flag_out));
   // Only a clean single command clears the load error
   csf_sticky u_lderr (.clock_in(clock_in), .rst_b_in(rst_b_in),
      .set_in(ld_multi | (ld_one & load_value_bad_in)), .clear_in(accept_next),
      .flag_out(load_error_out));
   csf_sticky u_supply (.clock_in(clock_in), .rst_b_in(rst_b_in), .set_in(supply_fault_in),
      .clear_in(err_clr), .flag_out(supply_error_out));
   csf_sticky u_do1err (.clock_in(clock_in), .rst_b_in(rst_b_in), .set_in(output_one_fault_in),
      .clear_in(err_clr), .flag_out(output_one_error_out));
   // Not touched by the error ack bit
   csf_sticky u_para (.clock_in(clock_in), .rst_b_in(rst_b_in), .set_in(param_error_in),
      .clear_in(param_ok_in), .flag_out(param_error_out));

   property p_cmp2_hold;
      @(posedge clock_in) disable iff (!rst_b_in)
      compare_two_hit_flag_out && !clr_lvl |=> compare_two_hit_flag_out;
   endproperty
   a_cmp2_hold: assert property (p_cmp2_hold) else $error("hit flag lost");

   property p_cmp2_reset;
      @(posedge clock_in) disable iff (!rst_b_in)
      output_two_in && clr_lvl |=> compare_two_hit_flag_out;
   endproperty
   a_cmp2_reset: assert property (p_cmp2_reset) else $error("hit flag not set again");

   property p_cmp2_manual;
      @(posedge clock_in) disable iff (!rst_b_in)
      manual_output_two_level_in && !output_two_enable_in |=> compare_two_hit_flag_out;
   endproperty
   a_cmp2_manual: assert property (p_cmp2_manual) else $error("manual level not flagged");

   property p_di_level;
      @(posedge clock_in) disable iff (!rst_b_in)
      ##1 input_level_flag_out == $past(di_sync_reg[1]);
   endproperty
   a_di_level: assert property (p_di_level) else $error("input level wrong");

   property p_mirror;
      @(posedge clock_in) disable iff (!rst_b_in)
      ##1 output_one_state_out == $past(output_one_in) &&
          output_two_state_out == $past(output_two_in);
   endproperty
   a_mirror: assert property (p_mirror) else $error("output mirror wrong");

   property p_zero;
      @(posedge clock_in) disable iff (!rst_b_in)
      zero_cross_evt_in && no_main_dir_in |=> zero_cross_flag_out;
   endproperty
   a_zero: assert property (p_zero) else $error("zero cross not flagged");

   property p_load_err;
      @(posedge clock_in) disable iff (!rst_b_in)
      ld_multi |=> load_error_out && !load_accept_out;
   endproperty
   a_load_err: assert property (p_load_err) else $error("load mix not refused");

   property p_iso;
      @(posedge clock_in) disable iff (!rst_b_in)
      isochrone_mode_in && !bus_cycle_in |=>
         $stable(status_clear_active_out) && $stable(load_busy_flag_out);
   endproperty
   a_iso: assert property (p_iso) else $error("handshake moved between bus cycles");

   property p_para;
      @(posedge clock_in) disable iff (!rst_b_in)
      param_error_out && !param_ok_in |=> param_error_out;
   endproperty
   a_para: assert property (p_para) else $error("param error dropped");

   property p_diag;
      @(posedge clock_in) disable iff (!rst_b_in)
      !group_diag_enable_in |=> !diag_report_out;
   endproperty
   a_diag: assert property (p_diag) else $error("diag without enable");

   property p_err_cont;
      @(posedge clock_in) disable iff (!rst_b_in)
      error_ack_bit_in || master_stop_in |=> supply_error_out == $past(supply_fault_in);
   endproperty
   a_err_cont: assert property (p_err_cont) else $error("error not transparent");

   property p_clear;
      @(posedge clock_in) disable iff (!rst_b_in)
      clr_lvl && !upper_limit_evt_in |=> !upper_limit_flag_out ##0 status_clear_active_out;
   endproperty
   a_clear: assert property (p_clear) else $error("flag not cleared");
endmodule : csf_status

// ### tb/csf_ctrl_model.sv
// Controller model for the clear and load handshakes
`timescale 1ns/10ps
module csf_ctrl_model (
   // Clock and bus step
   input  wire logic       clock_in,
   input  wire logic       step_in,
   // Bench commands
   input  wire logic       clr_go_in,
   input  wire logic       ld_go_in,
   input  wire logic [4:0] ld_mask_in,
   // Device answers
   input  wire logic       active_in,
   input  wire logic       busy_in,
   input  wire logic       load_err_in,
   // Controller outputs
   output logic            request_out,
   output logic [4:0]      cmd_out
);
   logic act_seen;
   logic busy_seen;
   logic err_seen;

   initial begin
      request_out = 1'b0;
      cmd_out     = 5'h00;
      {act_seen, busy_seen, err_seen} = 3'h0;
   end
   // Answers are read at a bus step, so a reaction costs one more step
   always @(posedge clock_in) begin
      if (step_in) begin
         {act_seen, busy_seen, err_seen} <= {active_in, busy_in, load_err_in};
      end
   end
   // Writes only after bus steps, like a cyclic master
   always @(negedge clock_in) begin
      if (step_in) begin
         if (clr_go_in && !act_seen) begin
            request_out <= 1'b1;
         end else if (act_seen) begin
            request_out <= 1'b0;
         end
         // Several bits only when the bench asks for a faulty load
         if (ld_go_in && !busy_seen) begin
            cmd_out <= ld_mask_in;
         end else if (busy_seen || err_seen) begin
            cmd_out <= 5'h00;
         end
      end
   end
endmodule : csf_ctrl_model

// ### tb/csf_status_test.sv
// Self-checking bench of the counter status feedback block
`timescale 1ns/10ps
module csf_status_test;
   logic       clock_in, rst_b_in, clr_go, ld_go, req, bad, ack, man2, en2, iso, bus, stop;
   logic       gdiag, aux, o1, o2, gate, nmd, zc, up, lo, syn, sup, o1f, perr, pok;
   logic       cmp2_f, in_f, o1_s, o2_s, gate_f, busy, zc_f, up_f, lo_f, syn_f;
   logic       act, lerr, serr, o1e, pe, diag, acc;
   logic [4:0] mask, cmd;
   int         err_total, checked, cycles, acc_cnt, bcnt, bsy_cnt;

   csf_status u_csf_status (.clock_in(clock_in), .rst_b_in(rst_b_in),
      .status_clear_request_in(req), .error_ack_bit_in(ack), .manual_output_two_level_in(man2),
      .output_two_enable_in(en2), .load_compare_one_in(cmd[0]), .load_compare_two_in(cmd[1]),
      .load_count_direct_in(cmd[2]), .load_count_staged_in(cmd[3]),
      .output_param_change_in(cmd[4]), .isochrone_mode_in(iso), .bus_cycle_in(bus),
      .master_stop_in(stop), .group_diag_enable_in(gdiag), .auxiliary_input_in(aux),
      .output_one_in(o1), .output_two_in(o2), .gate_open_in(gate), .no_main_dir_in(nmd),
      .zero_cross_evt_in(zc), .upper_limit_evt_in(up), .lower_limit_evt_in(lo),
      .sync_success_in(syn), .load_value_bad_in(bad), .supply_fault_in(sup),
      .output_one_fault_in(o1f), .param_error_in(perr), .param_ok_in(pok),
      .compare_two_hit_flag_out(cmp2_f), .input_level_flag_out(in_f),
      .output_one_state_out(o1_s), .output_two_state_out(o2_s), .gate_open_flag_out(gate_f),
      .load_busy_flag_out(busy), .zero_cross_flag_out(zc_f), .upper_limit_flag_out(up_f),
      .lower_limit_flag_out(lo_f), .sync_done_flag_out(syn_f), .status_clear_active_out(act),
      .load_error_out(lerr), .supply_error_out(serr), .output_one_error_out(o1e),
      .param_error_out(pe), .diag_report_out(diag), .load_accept_out(acc));

   csf_ctrl_model u_csf_ctrl_model (.clock_in(clock_in), .step_in(!iso || bus),
      .clr_go_in(clr_go), .ld_go_in(ld_go), .ld_mask_in(mask), .active_in(act),
      .busy_in(busy), .load_err_in(lerr), .request_out(req), .cmd_out(cmd));

   initial begin
      clock_in = 1'b0;
      forever #50 clock_in = ~clock_in;
   end
   // Bus cycle pulse every six clocks, only in isochrone mode
   always @(negedge clock_in) begin
      bcnt <= (bcnt == 5) ? 0 : bcnt + 1;
      bus  <= iso && (bcnt == 0);
   end
   always @(posedge clock_in) begin
      if (acc === 1'b1) begin
         acc_cnt++;
      end
      if (busy === 1'b1) begin
         bsy_cnt++;
      end
      cycles++;
      if (cycles == 5000) begin
         err_total++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results

   task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(negedge clock_in);
   endtask : cyc

   task automatic clear_hs();
      clr_go <= 1'b1;
      while (req !== 1'b1) cyc(1);
      clr_go <= 1'b0;
      // Clearing must wait for the next bus step
      while (iso && bus !== 1'b1) begin
         chk("active_before_step", 5'h00, act);
         cyc(1);
      end
      while (act !== 1'b1) cyc(1);
      while (act !== 1'b0) cyc(1);
   endtask : clear_hs

   task automatic load_hs(input logic [4:0] m, input logic [4:0] n_acc, input logic e);
      int a0;
      int b0;
      a0 = acc_cnt;
      b0 = bsy_cnt;
      mask <= m;
      ld_go <= 1'b1;
      while (cmd === 5'h00) cyc(1);
      ld_go <= 1'b0;
      while (cmd !== 5'h00 || busy !== 1'b0) cyc(1);
      cyc(3);
      chk("load_accepts", n_acc, 5'(acc_cnt - a0));
      chk("load_error", e, lerr);
      chk("load_busy_seen", n_acc, 5'(bsy_cnt != b0));
   endtask : load_hs

   task automatic t_mirror();
      aux <= 1'b1; o1 <= 1'b1; o2 <= 1'b1; gate <= 1'b1;
      cyc(1);
      chk("mirrors", 5'h07, {o1_s, o2_s, gate_f});
      cyc(1);
      chk("input_early", 5'h00, in_f);
      cyc(1);
      chk("input_level", 5'h01, in_f);
      aux <= 1'b0; o1 <= 1'b0; o2 <= 1'b0; gate <= 1'b0;
      cyc(3);
      chk("mirrors_off", 5'h00, {in_f, o1_s, o2_s, gate_f});
   endtask : t_mirror

   task automatic t_flags();
      clear_hs();
      zc <= 1'b1;
      cyc(1);
      zc <= 1'b0;
      cyc(2);
      chk("zero_cross_with_dir", 5'h00, zc_f);
      {nmd, zc, up, lo, syn, o2} <= 6'h3F;
      cyc(1);
      {zc, up, lo, syn, o2} <= 5'h00;
      cyc(5);
      chk("flags_held", 5'h1F, {cmp2_f, zc_f, up_f, lo_f, syn_f});
      o2 <= 1'b1;
      clear_hs();
      chk("flags_cleared", 5'h10, {cmp2_f, zc_f, up_f, lo_f, syn_f});
      o2 <= 1'b0;
      clear_hs();
      chk("hit_cleared", 5'h00, cmp2_f);
   endtask : t_flags

   task automatic t_manual();
      en2 <= 1'b1; man2 <= 1'b1;
      cyc(2);
      chk("manual_enabled", 5'h00, cmp2_f);
      en2 <= 1'b0;
      cyc(2);
      chk("manual_disabled", 5'h01, cmp2_f);
      man2 <= 1'b0;
      clear_hs();
   endtask : t_manual

   task automatic t_load();
      for (int i = 0; i < 5; i++) begin
         load_hs(5'h01 << i, 5'h01, 1'b0);
      end
      bad <= 1'b1;
      load_hs(5'h04, 5'h00, 1'b1);
      bad <= 1'b0;
      load_hs(5'h10, 5'h01, 1'b0);
      load_hs(5'h12, 5'h00, 1'b1);
      load_hs(5'h08, 5'h01, 1'b0);
   endtask : t_load

   task automatic t_errors();
      gdiag <= 1'b1; sup <= 1'b1;
      cyc(2);
      chk("supply_diag", 5'h03, {serr, diag});
      sup <= 1'b0;
      cyc(3);
      chk("supply_latched", 5'h01, serr);
      ack <= 1'b1;
      cyc(2);
      chk("supply_acked", 5'h00, serr);
      o1f <= 1'b1; perr <= 1'b1;
      cyc(1);
      chk("follow_on", 5'h01, o1e);
      o1f <= 1'b0; perr <= 1'b0;
      cyc(1);
      chk("follow_off", 5'h00, o1e);
      ack <= 1'b0; gdiag <= 1'b0; stop <= 1'b1; o1f <= 1'b1;
      cyc(2);
      chk("param_kept_no_diag", 5'h06, {pe, o1e, diag});
      o1f <= 1'b0; pok <= 1'b1;
      cyc(1);
      chk("stop_follow_param_ok", 5'h00, {pe, o1e});
      pok <= 1'b0; stop <= 1'b0;
   endtask : t_errors

   task automatic t_iso();
      iso <= 1'b1; syn <= 1'b1;
      cyc(1);
      syn <= 1'b0;
      cyc(8);
      clear_hs();
      chk("iso_cleared", 5'h00, syn_f);
      load_hs(5'h02, 5'h01, 1'b0);
      iso <= 1'b0;
   endtask : t_iso

   initial begin
      {rst_b_in, clr_go, ld_go, bad, ack, man2, en2, iso, bus, stop, gdiag, aux} = '0;
      {o1, o2, gate, nmd, zc, up, lo, syn, sup, o1f, perr, pok} = '0;
      mask = 5'h00;
      {err_total, checked, cycles, acc_cnt, bcnt, bsy_cnt} = '0;
      cyc(3);
      rst_b_in <= 1'b1;
      cyc(1);
      chk("after_reset", 5'h00, {cmp2_f, act, busy, lerr, pe});
      t_mirror();
      t_flags();
      t_manual();
      t_load();
      t_errors();
      t_iso();
      results();
   end
endmodule : csf_status_test
